// ---- hw/dfo_top.sv ----
/*
 * Drive fault option parameter bank with its fault and alert effects.
 * Assumes register requests arrive decoded from the serial protocol as
 * one-cycle strobes, and that power_up marks a restart that keeps the
 * persistent parameter store.
 */
//
// Behaviour
// R1 - Bit 15 of special word one at 0 enables the phase connection check, at 1 disables it.
// R2 - Software keeps bits 0-1 and 3-7 of special word two at zero.
// R3 - Bit 2 of special word two clears an undervoltage fault automatically when 1, manually when 0.
// R4 - Bit 12 of the limit switch word routes a limit hit to the alert output when 0, to the error output when 1.
// R5 - The lowest hex digit of the limit switch word at 1 makes a repeated overtravel attempt a fault needing reset.
// R6 - Software keeps the middle two hex digits of the limit switch word at zero.
// R7 - A new limit switch word is stored at once but acts only after the next power-up.
// R8 - With the immediate foldback bit set, a foldback limit equal to the actual current raises a fault.
// R9 - The read-only foldback time constant word reports the constant picked by the level word.
// R10 - The foldback level word takes 1 to 4, resets to 1, and picks the reported time constant.
// R11 - Writes to the read-only word and values out of range are refused and leave the store unchanged.
`timescale 1ns/1ps
`default_nettype none
module dfo_top
    import dfo_pkg::*;
#(
    parameter logic [31:0] TC_L1 = 32'h0000_0001,
    parameter logic [31:0] TC_L2 = 32'h0000_0002,
    parameter logic [31:0] TC_L3 = 32'h0000_0003,
    parameter logic [31:0] TC_L4 = 32'h0000_0004
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Register access
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_ack,
    output logic reg_err,
    // Drive events
    input wire logic power_up,
    input wire logic fault_reset,
    input wire logic uv_detect,
    input wire logic limit_hit,
    input wire logic overtravel_retry,
    input wire logic [15:0] foldback_limit,
    input wire logic [15:0] actual_current,
    // Fault and output functions
    output logic phase_check_en,
    output logic uv_fault,
    output logic overtravel_fault,
    output logic foldback_fault,
    output logic alert_active,
    output logic error_detected,
    output logic [7:0] limit_do_code
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    logic [15:0] sf1_r;
    logic [15:0] sf2_r;
    logic [15:0] lsf_r;
    logic [15:0] lsf_active_r;
    logic [15:0] fbe_r;
    logic [15:0] flv_r;
    logic [31:0] ftc_val;
    logic mapped;
    logic range_ok;
    logic acc_ok;
    logic wr_go;
    logic [31:0] rd_val;
    logic fold_eq;
    logic retry_err;

    dfo_flt_if uv_if();
    dfo_flt_if ot_if();
    dfo_flt_if fb_if();

    function automatic logic in_range(input logic [31:0] v,
        input logic [15:0] lo, input logic [15:0] hi);
        return (v[31:16] == 16'h0000) && (v[15:0] >= lo) && (v[15:0] <= hi);
    endfunction

    // Address decode and range check
    always_comb begin
        mapped = 1'b1;
        range_ok = 1'b0;
        rd_val = 32'h0000_0000;
        case (reg_addr)
            ADDR_SF1: begin
                range_ok = in_range(reg_wdata, SF1_MIN, SF1_MAX);
                rd_val = {16'h0000, sf1_r};
            end
            ADDR_SF2: begin
                range_ok = in_range(reg_wdata, SF2_MIN, SF2_MAX);
                rd_val = {16'h0000, sf2_r};
            end
            ADDR_LSF: begin
                range_ok = in_range(reg_wdata, LSF_MIN, LSF_MAX);
                rd_val = {16'h0000, lsf_r};
            end
            ADDR_FBE: begin
                range_ok = in_range(reg_wdata, FBE_MIN, FBE_MAX);
                rd_val = {16'h0000, fbe_r};
            end
            ADDR_FTC: begin
                // R9 read-only word
                range_ok = 1'b0;
                rd_val = ftc_val;
            end
            ADDR_FLV: begin
                range_ok = in_range(reg_wdata, FLV_MIN, FLV_MAX);
                rd_val = {16'h0000, flv_r};
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // R11 refuse bad writes
    assign wr_go = reg_wr && !reg_rd && mapped && range_ok;
    assign acc_ok = reg_rd ? mapped : (mapped && range_ok);

    // Bus answer
    always_ff @(posedge mclk) begin
        if (reset) begin
            reg_ack <= 1'b0;
            reg_err <= 1'b0;
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_ack <= reg_wr || reg_rd;
            reg_err <= (reg_wr || reg_rd) && !acc_ok;
            if (reg_rd && mapped) begin
                reg_rdata <= rd_val;
            end
        end
    end

    // Special word one store
    always_ff @(posedge mclk) begin
        if (reset) begin
            sf1_r <= SF1_RST;
        end else if (wr_go && reg_addr == ADDR_SF1) begin
            sf1_r <= reg_wdata[15:0];
        end
    end

    // Special word two store
    always_ff @(posedge mclk) begin
        if (reset) begin
            sf2_r <= SF2_RST;
        end else if (wr_go && reg_addr == ADDR_SF2) begin
            sf2_r <= reg_wdata[15:0];
        end
    end

    // R7 stored now, active at power-up
    always_ff @(posedge mclk) begin
        if (reset) begin
            lsf_r <= LSF_RST;
        end else if (wr_go && reg_addr == ADDR_LSF) begin
            lsf_r <= reg_wdata[15:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            lsf_active_r <= LSF_RST;
        end else if (power_up) begin
            lsf_active_r <= lsf_r;
        end
    end

    // Foldback enable store
    always_ff @(posedge mclk) begin
        if (reset) begin
            fbe_r <= FBE_RST;
        end else if (wr_go && reg_addr == ADDR_FBE) begin
            fbe_r <= reg_wdata[15:0];
        end
    end

    // R10 level store
    always_ff @(posedge mclk) begin
        if (reset) begin
            flv_r <= FLV_RST;
        end else if (wr_go && reg_addr == ADDR_FLV) begin
            flv_r <= reg_wdata[15:0];
        end
    end

    // R10 level selects constant
    dfo_fold_table #(
        .TC_L1(TC_L1),
        .TC_L2(TC_L2),
        .TC_L3(TC_L3),
        .TC_L4(TC_L4)
    ) u_table (
        .mclk(mclk),
        .reset(reset),
        .level(flv_r),
        .time_const(ftc_val)
    );

    // R3 undervoltage clear mode
    assign uv_if.set = uv_detect;
    assign uv_if.cond = uv_detect;
    assign uv_if.auto_clr = sf2_r[SF2_UV_AUTO_BIT];
    assign uv_if.man_clr = fault_reset;

    // R5 repeated overtravel attempt
    assign retry_err = lsf_active_r[3:0] == LSF_RETRY_ERR;
    assign ot_if.set = overtravel_retry && retry_err;
    assign ot_if.cond = 1'b0;
    assign ot_if.auto_clr = 1'b0;
    assign ot_if.man_clr = fault_reset;

    // R8 immediate foldback fault
    assign fold_eq = foldback_limit == actual_current;
    assign fb_if.set = fbe_r[FBE_EN_BIT] && fold_eq;
    assign fb_if.cond = fbe_r[FBE_EN_BIT] && fold_eq;
    assign fb_if.auto_clr = 1'b0;
    assign fb_if.man_clr = fault_reset;

    dfo_fault_latch u_uv (.mclk(mclk), .reset(reset), .flt(uv_if));
    dfo_fault_latch u_ot (.mclk(mclk), .reset(reset), .flt(ot_if));
    dfo_fault_latch u_fb (.mclk(mclk), .reset(reset), .flt(fb_if));

    assign uv_fault = uv_if.fault;
    assign overtravel_fault = ot_if.fault;
    assign foldback_fault = fb_if.fault;

    // R1 phase check enable
    always_ff @(posedge mclk) begin
        if (reset) begin
            phase_check_en <= !SF1_RST[SF1_PHASE_BIT];
        end else begin
            phase_check_en <= !sf1_r[SF1_PHASE_BIT];
        end
    end

    // R4 limit hit routing
    always_ff @(posedge mclk) begin
        if (reset) begin
            alert_active <= 1'b0;
            error_detected <= 1'b0;
            limit_do_code <= DO_NONE_CODE;
        end else begin
            alert_active <= limit_hit && !lsf_active_r[LSF_ROUTE_BIT];
            error_detected <= (limit_hit && lsf_active_r[LSF_ROUTE_BIT])
                || uv_if.fault || ot_if.fault || fb_if.fault;
            if (!limit_hit) begin
                limit_do_code <= DO_NONE_CODE;
            end else if (lsf_active_r[LSF_ROUTE_BIT]) begin
                limit_do_code <= DO_ERROR_CODE;
            end else begin
                limit_do_code <= DO_ALERT_CODE;
            end
        end
    end

    a_phase_follow: assert property ( // R1
        wr_go && reg_addr == ADDR_SF1
        |-> ##2 phase_check_en == !$past(reg_wdata[SF1_PHASE_BIT], 2))
        else $error("phase check enable wrong after write");
    a_uv_auto_clear: assert property ( // R3
        uv_fault && !uv_detect && sf2_r[SF2_UV_AUTO_BIT] |=> !uv_fault)
        else $error("undervoltage fault not auto cleared");
    a_uv_manual_hold: assert property ( // R3
        uv_fault && !sf2_r[SF2_UV_AUTO_BIT] && !fault_reset |=> uv_fault)
        else $error("undervoltage fault cleared without reset");
    a_limit_route: assert property ( // R4
        limit_hit |=> (alert_active == !$past(lsf_active_r[LSF_ROUTE_BIT]))
        && (limit_do_code == ($past(lsf_active_r[LSF_ROUTE_BIT])
        ? DO_ERROR_CODE : DO_ALERT_CODE)))
        else $error("limit hit routed to wrong output");
    a_retry_fault: assert property ( // R5
        overtravel_retry && lsf_active_r[3:0] == LSF_RETRY_ERR
        |=> overtravel_fault ##1 (overtravel_fault || $past(fault_reset)))
        else $error("overtravel retry fault missing");
    a_retry_quiet: assert property ( // R5
        !overtravel_fault && lsf_active_r[3:0] != LSF_RETRY_ERR
        |=> !overtravel_fault)
        else $error("overtravel fault without enable");
    a_persist_delay: assert property ( // R7
        wr_go && reg_addr == ADDR_LSF && !power_up
        |=> $stable(lsf_active_r) && lsf_r == $past(reg_wdata[15:0]))
        else $error("limit switch word acted before power-up");
    a_foldback_trip: assert property ( // R8
        fbe_r[FBE_EN_BIT] && foldback_limit == actual_current
        |=> foldback_fault)
        else $error("foldback fault not raised");
    a_level_table: assert property ( // R10
        flv_r == 16'h0004 ##1 flv_r == 16'h0004 |-> ftc_val == TC_L4)
        else $error("time constant does not follow level");
    a_display_read: assert property ( // R9
        reg_rd && reg_addr == ADDR_FTC |=> reg_ack && !reg_err
        && reg_rdata == $past(ftc_val))
        else $error("display word read wrong");
    a_reject_range: assert property ( // R11
        reg_wr && !reg_rd && reg_addr == ADDR_FLV
        && (reg_wdata == 32'h0000_0000 || reg_wdata > 32'h0000_0004)
        |=> $stable(flv_r) && reg_err)
        else $error("out of range level accepted");
    a_ro_refuse: assert property ( // R11
        reg_wr && !reg_rd && reg_addr == ADDR_FTC |=> reg_ack && reg_err)
        else $error("write to read-only word not refused");

    c_uv_auto: cover property (uv_fault ##1 !uv_fault);
    c_limit_err: cover property (limit_hit ##1 limit_do_code == DO_ERROR_CODE);
    c_fold_trip: cover property (!foldback_fault ##1 foldback_fault);
    c_power_up: cover property (lsf_active_r != lsf_r ##1 power_up);
endmodule // dfo_top
`default_nettype wire

// ---- common/dfo_pkg.sv ----
/*
 * Package of the drive fault option parameter bank: register addresses,
 * reset values, accepted ranges, field positions and output codes.
 * Assumes word addresses as carried by the serial register protocol.
 */
package dfo_pkg;
    // Register addresses
    localparam logic [15:0] ADDR_SF1 = 16'h0382;
    localparam logic [15:0] ADDR_SF2 = 16'h0384;
    localparam logic [15:0] ADDR_LSF = 16'h0388;
    localparam logic [15:0] ADDR_FBE = 16'h038E;
    localparam logic [15:0] ADDR_FTC = 16'h0390;
    localparam logic [15:0] ADDR_FLV = 16'h0392;
    // Reset values
    localparam logic [15:0] SF1_RST = 16'h0200;
    localparam logic [15:0] SF2_RST = 16'h0000;
    localparam logic [15:0] LSF_RST = 16'h0000;
    localparam logic [15:0] FBE_RST = 16'h0001;
    localparam logic [15:0] FLV_RST = 16'h0001;
    localparam logic [31:0] FTC_RST = 32'h0000_0000;
    // Accepted ranges
    localparam logic [15:0] SF1_MIN = 16'h0000;
    localparam logic [15:0] SF1_MAX = 16'hFFFC;
    localparam logic [15:0] SF2_MIN = 16'h0000;
    localparam logic [15:0] SF2_MAX = 16'h0004;
    localparam logic [15:0] LSF_MIN = 16'h0000;
    localparam logic [15:0] LSF_MAX = 16'h1111;
    localparam logic [15:0] FBE_MIN = 16'h0000;
    localparam logic [15:0] FBE_MAX = 16'h0001;
    localparam logic [15:0] FLV_MIN = 16'h0001;
    localparam logic [15:0] FLV_MAX = 16'h0004;
    // Field positions and values
    localparam int SF1_PHASE_BIT = 15;
    localparam int SF2_UV_AUTO_BIT = 2;
    localparam int LSF_ROUTE_BIT = 12;
    localparam int FBE_EN_BIT = 0;
    localparam logic [3:0] LSF_RETRY_ERR = 4'h1;
    // Digital output function codes
    localparam logic [7:0] DO_ALERT_CODE = 8'h11;
    localparam logic [7:0] DO_ERROR_CODE = 8'h07;
    localparam logic [7:0] DO_NONE_CODE = 8'h00;
endpackage

// ---- common/dfo_flt_if.sv ----
/*
 * Carrier between the option bank and one latched fault.
 * Assumes both ends run on the same control clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface dfo_flt_if;
    logic set;
    logic cond;
    logic auto_clr;
    logic man_clr;
    logic fault;
    modport latch (input set, input cond, input auto_clr, input man_clr,
        output fault);
    modport user (output set, output cond, output auto_clr,
        output man_clr, input fault);
endinterface
`default_nettype wire

// ---- hw/dfo_fault_latch.sv ----
/*
 * One sticky fault: set by its event, cleared once the cause is gone
 * and a manual or automatic fault reset applies.
 * Assumes a synchronous active-high reset on the control clock.
 */
`timescale 1ns/1ps
`default_nettype none
module dfo_fault_latch
    import dfo_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Fault carrier
    dfo_flt_if.latch flt
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    logic fault_r;

    // Set wins over clear
    always_ff @(posedge mclk) begin
        if (reset) begin
            fault_r <= 1'b0;
        end else if (flt.set) begin
            fault_r <= 1'b1;
        end else if (!flt.cond && (flt.auto_clr || flt.man_clr)) begin
            fault_r <= 1'b0;
        end
    end

    assign flt.fault = fault_r;

    a_set_wins: assert property (flt.set |=> fault_r)
        else $error("fault lost on set");
    a_hold_cond: assert property (fault_r && flt.cond |=> fault_r)
        else $error("fault cleared while cause present");
endmodule // dfo_fault_latch
`default_nettype wire

// ---- hw/dfo_fold_table.sv ----
/*
 * Foldback time constant lookup from the foldback level.
 * Assumes the level is already range checked to 1..4.
 */
`timescale 1ns/1ps
`default_nettype none
module dfo_fold_table
    import dfo_pkg::*;
#(
    parameter logic [31:0] TC_L1 = 32'h0000_0001,
    parameter logic [31:0] TC_L2 = 32'h0000_0002,
    parameter logic [31:0] TC_L3 = 32'h0000_0003,
    parameter logic [31:0] TC_L4 = 32'h0000_0004
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Level in, time constant out
    input wire logic [15:0] level,
    output logic [31:0] time_const
);
    always_ff @(posedge mclk) begin
        if (reset) begin
            time_const <= FTC_RST;
        end else begin
            case (level)
                16'h0001: time_const <= TC_L1;
                16'h0002: time_const <= TC_L2;
                16'h0003: time_const <= TC_L3;
                16'h0004: time_const <= TC_L4;
                default: time_const <= TC_L1;
            endcase
        end
    end
endmodule // dfo_fold_table
`default_nettype wire

// ---- verif/dfo_master_model.sv ----
/*
 * Register master model of the fault option bank: one task that issues a
 * read or write strobe and collects the answer.
 * Assumes strobes are taken on the rising edge, answered one edge later.
 */
`timescale 1ns/1ps
`default_nettype none
module dfo_master_model
    import dfo_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Register port
    output logic [15:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic reg_err
);
    initial begin
        reg_addr = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 32'h0000_0000;
    end

    // One strobe cycle, answer sampled in the following cycle
    task automatic access(input logic wr, input logic [15:0] a,
            input logic [31:0] d, output logic ack, output logic err,
            output logic [31:0] rdat);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = wr;
        reg_rd = ~wr;
        @(negedge mclk);
        ack = reg_ack;
        err = reg_err;
        rdat = reg_rdata;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
endmodule // dfo_master_model
`default_nettype wire

// ---- verif/testbench.sv ----
/*
 * Self-checking bench of the fault option bank: reset values, refusals,
 * foldback table, option effects, random register traffic.
 * Assumes the master model drives the register port.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    n_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); \
    end end
module testbench;
    import dfo_pkg::*;
    localparam logic [31:0] TC1 = 32'h0000_0010;
    localparam logic [31:0] TC2 = 32'h0001_0000;
    localparam logic [31:0] TC3 = 32'h7654_3210;
    localparam logic [31:0] TC4 = 32'hFFFF_FFFF;
    logic mclk, reset, power_up, fault_reset, uv_detect, limit_hit;
    logic overtravel_retry, reg_wr, reg_rd, reg_ack, reg_err;
    logic [15:0] foldback_limit, actual_current, reg_addr, rng, v, ra;
    logic [31:0] reg_wdata, reg_rdata;
    logic phase_check_en, uv_fault, overtravel_fault, foldback_fault;
    logic alert_active, error_detected;
    logic [7:0] limit_do_code;
    logic [15:0] sh [0:4];
    logic [15:0] addrs [0:6] = '{ADDR_SF1, ADDR_SF2, ADDR_LSF, ADDR_FBE,
        ADDR_FLV, ADDR_FTC, 16'h0391};
    logic [15:0] cw_a [0:8] = '{ADDR_FTC, ADDR_SF2, ADDR_LSF, ADDR_FBE,
        ADDR_FLV, ADDR_FLV, ADDR_SF1, ADDR_SF1, 16'h0391};
    logic [31:0] cw_d [0:8] = '{32'h5, 32'h5, 32'h1112, 32'h2, 32'h0,
        32'h5, 32'hFFFD, 32'h0001_0000, 32'h1};
    int n_errors, samples_checked;

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    dfo_master_model mm (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_ack(reg_ack), .reg_err(reg_err));

    dfo_top #(.TC_L1(TC1), .TC_L2(TC2), .TC_L3(TC3), .TC_L4(TC4)) dut_u (
        .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_ack(reg_ack), .reg_err(reg_err), .power_up(power_up),
        .fault_reset(fault_reset), .uv_detect(uv_detect),
        .limit_hit(limit_hit), .overtravel_retry(overtravel_retry),
        .foldback_limit(foldback_limit), .actual_current(actual_current),
        .phase_check_en(phase_check_en), .uv_fault(uv_fault),
        .overtravel_fault(overtravel_fault),
        .foldback_fault(foldback_fault), .alert_active(alert_active),
        .error_detected(error_detected), .limit_do_code(limit_do_code));

    function automatic logic [15:0] xs();
        rng ^= rng << 7;
        rng ^= rng >> 9;
        rng ^= rng << 8;
        return rng;
    endfunction

    function automatic int reg_idx(input logic [15:0] a);
        case (a)
            ADDR_SF1: return 0;
            ADDR_SF2: return 1;
            ADDR_LSF: return 2;
            ADDR_FBE: return 3;
            ADDR_FLV: return 4;
            ADDR_FTC: return 5;
            default: return 6;
        endcase
    endfunction

    function automatic logic refused(input logic [15:0] a,
            input logic [31:0] d);
        if (d[31:16] !== 16'h0000) return 1'b1;
        case (a)
            ADDR_SF1: return d[15:0] > SF1_MAX;
            ADDR_SF2: return d[15:0] > SF2_MAX;
            ADDR_LSF: return d[15:0] > LSF_MAX;
            ADDR_FBE: return d[15:0] > FBE_MAX;
            ADDR_FLV: return d[15:0] < FLV_MIN || d[15:0] > FLV_MAX;
            default: return 1'b1;
        endcase
    endfunction

    function automatic logic [31:0] fold_tc(input logic [15:0] lv);
        case (lv)
            16'h0001: return TC1;
            16'h0002: return TC2;
            16'h0003: return TC3;
            default: return TC4;
        endcase
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic ack, err, exp_err;
        logic [31:0] rdat;
        exp_err = refused(a, d);
        mm.access(1'b1, a, d, ack, err, rdat);
        `CHK({ack, err}, {1'b1, exp_err})
        if (!exp_err) sh[reg_idx(a)] = d[15:0];
    endtask

    task automatic rd(input logic [15:0] a);
        logic ack, err;
        logic [31:0] rdat;
        int i;
        i = reg_idx(a);
        mm.access(1'b0, a, 32'h0, ack, err, rdat);
        `CHK({ack, err}, {1'b1, (i == 6)})
        if (i < 5) `CHK(rdat, {16'h0000, sh[i]})
        else if (i == 5) `CHK(rdat, fold_tc(sh[4]))
    endtask

    task automatic pulse_pu();
        power_up = 1'b1;
        cyc(1);
        power_up = 1'b0;
        cyc(1);
    endtask

    task automatic pulse_fr();
        fault_reset = 1'b1;
        cyc(1);
        fault_reset = 1'b0;
        cyc(1);
    endtask

    task automatic tally_and_finish();
        if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        {reset, power_up, fault_reset, uv_detect} = 4'hF;
        {power_up, fault_reset, uv_detect, limit_hit} = 4'h0;
        overtravel_retry = 1'b0;
        foldback_limit = 16'h0001;
        actual_current = 16'h0000;
        rng = 16'h495A;
        sh = '{SF1_RST, SF2_RST, LSF_RST, FBE_RST, FLV_RST};
        cyc(6);
        reset = 1'b0;
        for (int k = 0; k < 7; k++) rd(addrs[k]);
        `CHK(phase_check_en, 1'b1)
        for (int k = 0; k < 9; k++) wr(cw_a[k], cw_d[k]);
        for (int k = 0; k < 7; k++) rd(addrs[k]);
        for (int k = 1; k < 5; k++) begin
            wr(ADDR_FLV, k);
            rd(ADDR_FTC);
        end
        for (int k = 0; k < 10; k++) begin
            v = (k < 2) ? (k ? 16'h7FFC : 16'h8000) : (xs() & 16'hFFFC);
            wr(ADDR_SF1, {16'h0000, v});
            cyc(1);
            `CHK(phase_check_en, ~sh[0][15])
        end
        for (int k = 0; k < 40; k++) begin
            v = xs() >> rng[3:0];
            ra = addrs[rng[6:4] % 6];
            if (ra == ADDR_SF2) v &= 16'h0004;
            if (ra == ADDR_LSF) v &= 16'h1001;
            wr(ra, {(rng[9:7] == 0) ? rng : 16'h0000, v});
            rd(ra);
        end
        for (int m = 0; m < 2; m++) begin
            wr(ADDR_SF2, m ? 32'h4 : 32'h0);
            uv_detect = 1'b1;
            cyc(3);
            `CHK({uv_fault, error_detected}, 2'b11)
            uv_detect = 1'b0;
            cyc(3);
            `CHK(uv_fault, (m == 0))
            pulse_fr();
            `CHK(uv_fault, 1'b0)
        end
        wr(ADDR_LSF, 32'h0);
        pulse_pu();
        wr(ADDR_LSF, 32'h1001);
        rd(ADDR_LSF);
        limit_hit = 1'b1;
        cyc(2);
        `CHK({alert_active, limit_do_code}, {1'b1, DO_ALERT_CODE})
        limit_hit = 1'b0;
        cyc(2);
        `CHK({alert_active, limit_do_code}, {1'b0, DO_NONE_CODE})
        pulse_pu();
        limit_hit = 1'b1;
        cyc(2);
        `CHK({alert_active, error_detected}, 2'b01)
        `CHK(limit_do_code, DO_ERROR_CODE)
        limit_hit = 1'b0;
        for (int m = 0; m < 2; m++) begin
            overtravel_retry = 1'b1;
            cyc(1);
            overtravel_retry = 1'b0;
            cyc(5);
            `CHK(overtravel_fault, (m == 0))
            pulse_fr();
            `CHK(overtravel_fault, 1'b0)
            wr(ADDR_LSF, 32'h0);
            pulse_pu();
        end
        for (int k = 0; k < 10; k++) begin
            v = xs();
            wr(ADDR_FBE, k & 1);
            actual_current = v;
            foldback_limit = (k & 2) ? v : v ^ 16'h0100;
            cyc(3);
            `CHK(foldback_fault, (k & 3) == 3)
            foldback_limit = ~v;
            pulse_fr();
            `CHK(foldback_fault, 1'b0)
        end
        tally_and_finish();
    end
endmodule // testbench
`undef CHK
`default_nettype wire
